// File: core/prescale_reset_pkg.sv
// Package for the peripheral clock divider bank and soft-reset register
package prescale_reset_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] DIV_BANK_1_OFS = 8'h08;
  localparam logic [7:0] SOFT_RESET_OFS = 8'h0C;
  localparam logic [31:0] DIV_BANK_1_RST = 32'h0000_0000;
  localparam logic [31:0] SOFT_RESET_RST = 32'h0000_0000;
  // Writable bit masks; all other bits are reserved and read as zero
  localparam logic [31:0] DIV_BANK_1_MASK = 32'hF773_7777;
  localparam logic [31:0] SOFT_RESET_MASK = 32'h01F3_3BCF;
  // Field positions (low bit)
  localparam int unsigned CLKOUT_LSB = 28;
  localparam int unsigned I2C2_LSB = 24;
  localparam int unsigned WDT_LSB = 20;
  localparam int unsigned TICK_LSB = 16;
  localparam int unsigned AUDIO_LSB = 12;
  localparam int unsigned I2C1_LSB = 8;
  localparam int unsigned USART2_LSB = 4;
  localparam int unsigned USART1_LSB = 0;
  // Highest legal code per field
  localparam logic [3:0] CLKOUT_MAX = 4'h9;
  localparam logic [3:0] WDT_MAX = 4'h5;
  localparam logic [3:0] STD_MAX = 4'h4;
  localparam logic [3:0] TICK_MAX = 4'h3;
  localparam int unsigned CNT_W = 9;
  localparam int unsigned N_DIV = 8;
  localparam int unsigned N_RST = 32;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage

// File: core/prescale_reset.sv
// Peripheral clock divider bank and self-clearing peripheral soft resets
`timescale 1ns/1ps
// Notes on behaviour
// - Clock-out divider bits 31:28 divide source by 2^code, codes 0 to 9.
// - Second I2C divider bits 26:24 divide system clock by 1 to 16.
// - Watchdog divider bits 22:20 divide system clock by 1 to 32.
// - System tick divider bits 17:16 divide system clock by 1, 2, 4, 8.
// - Audio serial divider bits 14:12 divide system clock by 1 to 16.
// - First I2C divider bits 10:8 divide system clock by 1 to 16.
// - Second USART divider bits 6:4 divide system clock by 1 to 16.
// - First USART divider bits 2:0 divide system clock by 1 to 16.
// - Reset bits self-clear after a written 1; written 0 does nothing.
// - Bits 24..20 reset watchdog, calendar, audio, first I2C, second I2C.
// - Bits 17,16 reset USARTs; bits 13,12 reset sync serial ports.
// - Bit 11 converter; bits 9,8 wide timers; bits 7,6 narrow timers.
// - Bits 3..0 reset I/O ports 3..0 independently.
module prescale_reset (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Register port
  input wire prescale_reset_pkg::reg_req_t i_req,
  output logic [31:0] o_rdata,
  // Clock-out source, already selected outside
  input wire logic i_clkout_src_en,
  // Divided clock enables, one system clock cycle wide
  output logic o_clkout_en,
  output logic o_second_i2c_clk_en,
  output logic o_watchdog_clk_en,
  output logic o_system_tick_clk_en,
  output logic o_audio_serial_clk_en,
  output logic o_first_i2c_clk_en,
  output logic o_second_usart_clk_en,
  output logic o_first_usart_clk_en,
  // Peripheral soft resets, active high
  output logic o_watchdog_soft_reset,
  output logic o_calendar_soft_reset,
  output logic o_audio_serial_soft_reset,
  output logic o_first_i2c_soft_reset,
  output logic o_second_i2c_soft_reset,
  output logic o_second_usart_soft_reset,
  output logic o_first_usart_soft_reset,
  output logic o_second_sync_serial_soft_reset,
  output logic o_first_sync_serial_soft_reset,
  output logic o_converter_soft_reset,
  output logic o_second_wide_timer_soft_reset,
  output logic o_first_wide_timer_soft_reset,
  output logic o_second_narrow_timer_soft_reset,
  output logic o_first_narrow_timer_soft_reset,
  output logic o_io_port3_soft_reset,
  output logic o_io_port2_soft_reset,
  output logic o_io_port1_soft_reset,
  output logic o_io_port0_soft_reset
);
  import prescale_reset_pkg::*;

  logic [31:0] div_bank_q;
  logic [31:0] soft_reset_q;
  logic [31:0] rdata_q;
  logic [CNT_W-1:0] cnt_q [N_DIV];
  logic [N_DIV-1:0] tick_q;
  logic [N_DIV-1:0] step;
  logic [3:0] code [N_DIV];

  // Terminal count for a 2^code divider: all low code bits set
  function automatic logic [CNT_W-1:0] div_limit(input logic [3:0] c);
    div_limit = CNT_W'((10'h001 << c) - 10'h001);
  endfunction

  // Reserved codes are stored and read back as written; treat them as the largest legal ratio
  function automatic logic [3:0] clamp(input logic [3:0] c, input logic [3:0] mx);
    clamp = (c > mx) ? mx : c;
  endfunction

  wire write_div = i_req.wr && (i_req.addr == DIV_BANK_1_OFS);
  wire write_rst = i_req.wr && (i_req.addr == SOFT_RESET_OFS);

  // Divider bank register
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      div_bank_q <= DIV_BANK_1_RST;
    end else if (write_div) begin
      div_bank_q <= i_req.wdata & DIV_BANK_1_MASK;
    end
  end

  // A written 1 sets a bit for exactly one cycle, then hardware clears it
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      soft_reset_q <= SOFT_RESET_RST;
    end else if (write_rst) begin
      soft_reset_q <= i_req.wdata & SOFT_RESET_MASK;
    end else begin
      soft_reset_q <= SOFT_RESET_RST;
    end
  end

  // Read data one cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (i_req.rd) begin
      if (i_req.addr == DIV_BANK_1_OFS) begin
        rdata_q <= div_bank_q;
      end else if (i_req.addr == SOFT_RESET_OFS) begin
        rdata_q <= soft_reset_q;
      end else begin
        rdata_q <= 32'h0000_0000;
      end
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end
  assign o_rdata = rdata_q;

  // Field decode into effective codes
  always_comb begin
    code[0] = clamp(div_bank_q[CLKOUT_LSB +: 4], CLKOUT_MAX);
    code[1] = clamp({1'b0, div_bank_q[I2C2_LSB +: 3]}, STD_MAX);
    code[2] = clamp({1'b0, div_bank_q[WDT_LSB +: 3]}, WDT_MAX);
    code[3] = clamp({2'b00, div_bank_q[TICK_LSB +: 2]}, TICK_MAX);
    code[4] = clamp({1'b0, div_bank_q[AUDIO_LSB +: 3]}, STD_MAX);
    code[5] = clamp({1'b0, div_bank_q[I2C1_LSB +: 3]}, STD_MAX);
    code[6] = clamp({1'b0, div_bank_q[USART2_LSB +: 3]}, STD_MAX);
    code[7] = clamp({1'b0, div_bank_q[USART1_LSB +: 3]}, STD_MAX);
  end

  // Clock-out counts its own source enable; the others count system clocks
  assign step = {{(N_DIV-1){1'b1}}, i_clkout_src_en};

  // Each divider emits one enable pulse per 2^code counted edges. A new code
  // applies to the running count at once and may cut one period short, so software resets the peripheral after it.
  for (genvar g = 0; g < N_DIV; g++) begin : g_div
    always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
        cnt_q[g] <= '0;
        tick_q[g] <= 1'b0;
      end else if (step[g]) begin
        if (cnt_q[g] >= div_limit(code[g])) begin
          cnt_q[g] <= '0;
          tick_q[g] <= 1'b1;
        end else begin
          cnt_q[g] <= cnt_q[g] + CNT_W'(1);
          tick_q[g] <= 1'b0;
        end
      end else begin
        tick_q[g] <= 1'b0;
      end
    end
  end

  assign o_clkout_en = tick_q[0];
  assign o_second_i2c_clk_en = tick_q[1];
  assign o_watchdog_clk_en = tick_q[2];
  assign o_system_tick_clk_en = tick_q[3];
  assign o_audio_serial_clk_en = tick_q[4];
  assign o_first_i2c_clk_en = tick_q[5];
  assign o_second_usart_clk_en = tick_q[6];
  assign o_first_usart_clk_en = tick_q[7];

  // Reset outputs straight from the register bits
  assign o_watchdog_soft_reset = soft_reset_q[24];
  assign o_calendar_soft_reset = soft_reset_q[23];
  assign o_audio_serial_soft_reset = soft_reset_q[22];
  assign o_first_i2c_soft_reset = soft_reset_q[21];
  assign o_second_i2c_soft_reset = soft_reset_q[20];
  assign o_second_usart_soft_reset = soft_reset_q[17];
  assign o_first_usart_soft_reset = soft_reset_q[16];
  assign o_second_sync_serial_soft_reset = soft_reset_q[13];
  assign o_first_sync_serial_soft_reset = soft_reset_q[12];
  assign o_converter_soft_reset = soft_reset_q[11];
  assign o_second_wide_timer_soft_reset = soft_reset_q[9];
  assign o_first_wide_timer_soft_reset = soft_reset_q[8];
  assign o_second_narrow_timer_soft_reset = soft_reset_q[7];
  assign o_first_narrow_timer_soft_reset = soft_reset_q[6];
  assign o_io_port3_soft_reset = soft_reset_q[3];
  assign o_io_port2_soft_reset = soft_reset_q[2];
  assign o_io_port1_soft_reset = soft_reset_q[1];
  assign o_io_port0_soft_reset = soft_reset_q[0];

  // Checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);

  rst_pulse_a: assert property (write_rst && i_req.wdata[24] |=>
    o_watchdog_soft_reset ##1 !o_watchdog_soft_reset [*1] or write_rst)
    else $error("watchdog reset pulse wrong");
  rst_zero_a: assert property (write_rst && !i_req.wdata[0] |=> !o_io_port0_soft_reset)
    else $error("written zero caused reset");
  rst_resv_a: assert property ((soft_reset_q & ~SOFT_RESET_MASK) == 32'h0)
    else $error("reserved reset bit set");
  rst_ports_a: assert property (write_rst && (i_req.wdata[3:0] == 4'h5) |=>
    o_io_port0_soft_reset && o_io_port2_soft_reset && !o_io_port1_soft_reset
    && !o_io_port3_soft_reset) else $error("port resets not independent");
  div_resv_a: assert property (write_div |=> (div_bank_q & ~DIV_BANK_1_MASK) == 32'h0)
    else $error("reserved divider bit stored");
  // The first edge after reset still shows the enable cleared by reset
  usart_div1_a: assert property (!$past(i_rst) && div_bank_q[2:0] == 3'h0
    && $past(div_bank_q[2:0]) == 3'h0 && $past(div_bank_q[2:0], 2) == 3'h0
    |-> o_first_usart_clk_en)
    else $error("divide by one not every cycle");
  tick_div8_a: assert property ($rose(o_system_tick_clk_en)
    && div_bank_q[TICK_LSB +: 2] == 2'h3 |=>
    (!o_system_tick_clk_en [*7] ##1 o_system_tick_clk_en) or (##[0:7] write_div))
    else $error("tick divide by eight wrong");
  wdt_space_a: assert property ($rose(o_watchdog_clk_en) && div_bank_q[22:20] == 3'h1
    |=> !o_watchdog_clk_en or write_div)
    else $error("watchdog divide by two wrong");
  rd_data_a: assert property (i_req.rd && i_req.addr == DIV_BANK_1_OFS |=>
    o_rdata == $past(div_bank_q)) else $error("divider readback wrong");

  div_seen_c: cover property (write_div ##1 o_clkout_en);
  rst_seen_c: cover property (write_rst && i_req.wdata[24] ##1 o_watchdog_soft_reset);

  // Soft reset bits follow the written word for one cycle
  rst_grp11_a: assert property (write_rst |=>
    {o_watchdog_soft_reset, o_calendar_soft_reset, o_audio_serial_soft_reset,
    o_first_i2c_soft_reset, o_second_i2c_soft_reset} == $past(i_req.wdata[24:20]))
    else $error("watchdog to second I2C reset map wrong");
  rst_grp12_a: assert property (write_rst |=>
    {o_second_usart_soft_reset, o_first_usart_soft_reset} == $past(i_req.wdata[17:16])
    && {o_second_sync_serial_soft_reset, o_first_sync_serial_soft_reset}
    == $past(i_req.wdata[13:12]))
    else $error("serial port reset map wrong");
  rst_grp13_a: assert property (write_rst |=>
    o_converter_soft_reset == $past(i_req.wdata[11])
    && {o_second_wide_timer_soft_reset, o_first_wide_timer_soft_reset,
    o_second_narrow_timer_soft_reset, o_first_narrow_timer_soft_reset}
    == $past(i_req.wdata[9:6]))
    else $error("converter or timer reset map wrong");
  rst_grp14_a: assert property (write_rst |=>
    {o_io_port3_soft_reset, o_io_port2_soft_reset, o_io_port1_soft_reset,
    o_io_port0_soft_reset} == $past(i_req.wdata[3:0]))
    else $error("I/O port reset map wrong");
  rst_write0_a: assert property (write_rst |=>
    (soft_reset_q & ~$past(i_req.wdata)) == 32'h0000_0000)
    else $error("soft reset bit set without a written one");
  rst_clear_a: assert property (!write_rst |=> soft_reset_q == 32'h0000_0000)
    else $error("soft reset bit did not clear");
  rst_idle_a: assert property ($past(i_rst) |->
    tick_q == '0 && soft_reset_q == 32'h0000_0000)
    else $error("outputs active right after reset");

  // Register port
  rd_unmap_a: assert property (i_req.rd && i_req.addr != DIV_BANK_1_OFS
    && i_req.addr != SOFT_RESET_OFS |=> o_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  wr_unmap_a: assert property (i_req.wr && i_req.addr != DIV_BANK_1_OFS
    && i_req.addr != SOFT_RESET_OFS |=>
    $stable(div_bank_q) && soft_reset_q == 32'h0000_0000)
    else $error("unmapped write changed a register");
  rd_idle_a: assert property (!i_req.rd |=> o_rdata == 32'h0000_0000)
    else $error("read data outside read cycle");
  rd_rst_a: assert property (i_req.rd && i_req.addr == SOFT_RESET_OFS |=>
    o_rdata == $past(soft_reset_q))
    else $error("soft reset readback wrong");
  div_write_a: assert property (write_div |=>
    div_bank_q == ($past(i_req.wdata) & DIV_BANK_1_MASK))
    else $error("divider write not stored");
  div_keep_a: assert property (!write_div |=> $stable(div_bank_q))
    else $error("divider bank changed without a write");
  src_gate_a: assert property (!i_clkout_src_en |=> !o_clkout_en)
    else $error("clock-out enable without a source edge");

  // Field decode: legal codes pass, reserved codes clamp to the largest ratio
  clkout_pass_a: assert property (div_bank_q[CLKOUT_LSB +: 4] <= CLKOUT_MAX |->
    code[0] == div_bank_q[CLKOUT_LSB +: 4])
    else $error("clock-out code altered");
  clkout_clamp_a: assert property (div_bank_q[CLKOUT_LSB +: 4] > CLKOUT_MAX |->
    code[0] == CLKOUT_MAX)
    else $error("clock-out reserved code not clamped");
  i2c2_pass_a: assert property ({1'b0, div_bank_q[I2C2_LSB +: 3]} <= STD_MAX |->
    code[1] == {1'b0, div_bank_q[I2C2_LSB +: 3]})
    else $error("second I2C code altered");
  i2c2_clamp_a: assert property ({1'b0, div_bank_q[I2C2_LSB +: 3]} > STD_MAX |->
    code[1] == STD_MAX)
    else $error("second I2C reserved code not clamped");
  wdt_pass_a: assert property ({1'b0, div_bank_q[WDT_LSB +: 3]} <= WDT_MAX |->
    code[2] == {1'b0, div_bank_q[WDT_LSB +: 3]})
    else $error("watchdog code altered");
  wdt_clamp_a: assert property ({1'b0, div_bank_q[WDT_LSB +: 3]} > WDT_MAX |->
    code[2] == WDT_MAX)
    else $error("watchdog reserved code not clamped");
  tick_pass_a: assert property (1'b1 |->
    code[3] == {2'b00, div_bank_q[TICK_LSB +: 2]})
    else $error("system tick code altered");
  audio_pass_a: assert property ({1'b0, div_bank_q[AUDIO_LSB +: 3]} <= STD_MAX |->
    code[4] == {1'b0, div_bank_q[AUDIO_LSB +: 3]})
    else $error("audio serial code altered");
  audio_clamp_a: assert property ({1'b0, div_bank_q[AUDIO_LSB +: 3]} > STD_MAX |->
    code[4] == STD_MAX)
    else $error("audio serial reserved code not clamped");
  i2c1_pass_a: assert property ({1'b0, div_bank_q[I2C1_LSB +: 3]} <= STD_MAX |->
    code[5] == {1'b0, div_bank_q[I2C1_LSB +: 3]})
    else $error("first I2C code altered");
  i2c1_clamp_a: assert property ({1'b0, div_bank_q[I2C1_LSB +: 3]} > STD_MAX |->
    code[5] == STD_MAX)
    else $error("first I2C reserved code not clamped");
  usart2_pass_a: assert property ({1'b0, div_bank_q[USART2_LSB +: 3]} <= STD_MAX |->
    code[6] == {1'b0, div_bank_q[USART2_LSB +: 3]})
    else $error("second USART code altered");
  usart2_clamp_a: assert property ({1'b0, div_bank_q[USART2_LSB +: 3]} > STD_MAX |->
    code[6] == STD_MAX)
    else $error("second USART reserved code not clamped");
  usart1_pass_a: assert property ({1'b0, div_bank_q[USART1_LSB +: 3]} <= STD_MAX |->
    code[7] == {1'b0, div_bank_q[USART1_LSB +: 3]})
    else $error("first USART code altered");
  usart1_clamp_a: assert property ({1'b0, div_bank_q[USART1_LSB +: 3]} > STD_MAX |->
    code[7] == STD_MAX)
    else $error("first USART reserved code not clamped");

  // Checker helper: counted source edges since each enable, and whether the
  // bank was rewritten meanwhile, since a rewrite may cut one period short
  logic [9:0] chk_since_q [N_DIV];
  logic [N_DIV-1:0] chk_dirty_q;

  for (genvar h = 0; h < N_DIV; h++) begin : g_chk
    always_ff @(posedge i_core_clk) begin
      if (i_rst) begin
        chk_since_q[h] <= 10'h000;
        chk_dirty_q[h] <= 1'b1;
      end else if (tick_q[h]) begin
        chk_since_q[h] <= {9'h000, step[h]};
        chk_dirty_q[h] <= write_div;
      end else begin
        chk_since_q[h] <= chk_since_q[h] + {9'h000, step[h]};
        if (write_div) begin
          chk_dirty_q[h] <= 1'b1;
        end
      end
    end

    gap_ratio_a: assert property (tick_q[h] && !chk_dirty_q[h] |->
      chk_since_q[h] == (10'h001 << code[h]))
      else $error("enable spacing differs from code");
    pulse_one_a: assert property (tick_q[h] && code[h] != 4'h0 |=> !tick_q[h])
      else $error("divided enable longer than one cycle");
  end

  rd_seen_c: cover property (i_req.rd && i_req.addr == SOFT_RESET_OFS);
  clamp_seen_c: cover property (write_div && i_req.wdata[CLKOUT_LSB +: 4] > CLKOUT_MAX);
  src_gap_c: cover property (!i_clkout_src_en ##2 o_clkout_en);
endmodule

// File: tb/periph_sink.sv
// Model of the peripherals that take the divided clocks and soft resets
`timescale 1ns/1ps
module periph_sink (
  // Clock
  input wire logic i_core_clk,
  // Divided clock enables and matching soft resets
  input wire logic [7:0] i_clk_en,
  input wire logic [7:0] i_soft_reset,
  // Ticks seen by each peripheral
  output logic [7:0][15:0] o_ticks
);
  // A peripheral only restarts cleanly after its reset, so a new ratio counts from zero
  always_ff @(posedge i_core_clk) begin
    for (int i = 0; i < 8; i++) begin
      if (i_soft_reset[i]) begin
        o_ticks[i] <= 16'h0000;
      end else if (i_clk_en[i]) begin
        o_ticks[i] <= o_ticks[i] + 16'h0001;
      end
    end
  end
endmodule

// File: tb/test_prescale_reset.sv
// Self-checking bench for the divider bank and soft-reset register
`timescale 1ns/1ps
module test_prescale_reset;
  import prescale_reset_pkg::*;
  // Bits 19:18 of the divider bank are reserved
  localparam logic [31:0] DIV_RD_MASK = 32'hF773_7777;
  logic i_core_clk;
  logic i_rst;
  logic i_clkout_src_en = 1'b1;
  logic half = 1'b0;
  logic ok;
  logic [7:0][15:0] ticks;
  reg_req_t i_req;
  logic [31:0] o_rdata;
  wire [7:0] en;
  wire [31:0] rv;
  wire [7:0] sr;
  wire [31:0] hit;
  logic [9:0] since [8] = '{default: 10'h000};
  logic [9:0] gap [8] = '{default: 10'h000};
  logic [31:0] word;
  logic [31:0] e;
  logic [31:0] g;
  int miscompares;
  int tests_run;
  assign hit = rv & SOFT_RESET_MASK;
  assign sr = {1'b0, rv[20], rv[24], 1'b0, rv[22], rv[21], rv[17], rv[16]};
  prescale_reset prescale_reset_inst (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_req(i_req),
    .o_rdata(o_rdata), .i_clkout_src_en(i_clkout_src_en), .o_clkout_en(en[7]),
    .o_second_i2c_clk_en(en[6]), .o_watchdog_clk_en(en[5]), .o_system_tick_clk_en(en[4]),
    .o_audio_serial_clk_en(en[3]), .o_first_i2c_clk_en(en[2]), .o_second_usart_clk_en(en[1]),
    .o_first_usart_clk_en(en[0]), .o_watchdog_soft_reset(rv[24]), .o_calendar_soft_reset(rv[23]),
    .o_audio_serial_soft_reset(rv[22]), .o_first_i2c_soft_reset(rv[21]),
    .o_second_i2c_soft_reset(rv[20]), .o_second_usart_soft_reset(rv[17]),
    .o_first_usart_soft_reset(rv[16]), .o_second_sync_serial_soft_reset(rv[13]),
    .o_first_sync_serial_soft_reset(rv[12]), .o_converter_soft_reset(rv[11]),
    .o_second_wide_timer_soft_reset(rv[9]), .o_first_wide_timer_soft_reset(rv[8]),
    .o_second_narrow_timer_soft_reset(rv[7]), .o_first_narrow_timer_soft_reset(rv[6]),
    .o_io_port3_soft_reset(rv[3]), .o_io_port2_soft_reset(rv[2]),
    .o_io_port1_soft_reset(rv[1]), .o_io_port0_soft_reset(rv[0]));
  periph_sink periph_sink_inst (.i_core_clk(i_core_clk), .i_clk_en(en), .i_soft_reset(sr),
    .o_ticks(ticks));
  // Clock-out source runs at half rate while half is set
  always @(posedge i_core_clk) begin
    i_clkout_src_en <= half ? ~i_clkout_src_en : 1'b1;
  end
  // Gap between enable pulses; a write clears it so a dead output cannot pass on stale data
  always @(posedge i_core_clk) begin
    for (int i = 0; i < 8; i++) begin
      if (en[i]) begin
        gap[i] <= since[i] + 10'h001;
        since[i] <= 10'h000;
      end else begin
        since[i] <= since[i] + 10'h001;
        if (i_req.wr) gap[i] <= 10'h000;
      end
    end
  end
  // Reserved codes clamp to the largest legal ratio
  function automatic logic [9:0] exp_gap(input logic [31:0] w, input int i);
    logic [3:0] c;
    logic [3:0] m;
    c = w[i*4 +: 4] & DIV_RD_MASK[i*4 +: 4];
    m = (i == 7) ? CLKOUT_MAX : (i == 5) ? WDT_MAX : (i == 4) ? TICK_MAX : STD_MAX;
    if (c > m) c = m;
    return 10'h001 << c;
  endfunction
  task automatic ck(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_req.addr <= a;
    i_req.wdata <= d;
    i_req.wr <= 1'b1;
    @(posedge i_core_clk);
    i_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    i_req.addr <= a;
    i_req.rd <= 1'b1;
    @(posedge i_core_clk);
    i_req.rd <= 1'b0;
    #1 ck("rdata", exp, o_rdata);
    @(posedge i_core_clk);
  endtask
  task automatic results();
    $display("Checks run %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    i_core_clk = 1'b0;
    forever #25 i_core_clk = ~i_core_clk;
  end
  initial begin
    repeat (100000) @(posedge i_core_clk);
    miscompares++;
    $display("MISMATCH run length expected end seen timeout");
    results();
  end
  initial begin
    i_rst = 1'b1;
    i_req <= '0;
    miscompares = 0;
    tests_run = 0;
    word = $urandom(22071);
    repeat (4) @(posedge i_core_clk);
    i_rst <= 1'b0;
    @(posedge i_core_clk);
    rd(DIV_BANK_1_OFS, DIV_BANK_1_RST);
    rd(SOFT_RESET_OFS, SOFT_RESET_RST);
    $display("Test reset values done");
    for (int k = 0; k < 14; k++) begin
      half <= (k == 3);
      word = (k < 10) ? {8{k[3:0]}} : (k < 12) ? 32'hFFFF_FFFF : $urandom;
      wr(DIV_BANK_1_OFS, word);
      @(posedge i_core_clk);
      wr(SOFT_RESET_OFS, 32'h01F3_0000);
      repeat (1100) @(posedge i_core_clk);
      #1;
      for (int i = 0; i < 8; i++) begin
        e = 32'(exp_gap(word, i));
        if (half && i == 7) e = e << 1;
        g = 32'(gap[i]);
        ck("div", e, g);
        // Ticks counted over 1099 edges since the peripheral reset
        if (i != 4 && i != 7) begin
          ok = (ticks[i] >= 1099 / e) && (ticks[i] <= 1099 / e + 1);
          ck("ticks", 32'h1, {31'h0, ok});
        end
      end
      @(posedge i_core_clk);
      rd(DIV_BANK_1_OFS, word & DIV_RD_MASK);
    end
    $display("Test divider ratios done");
    for (int b = 0; b < 48; b++) begin
      word = (b == 47) ? 32'h0 : (b < 32) ? (32'h1 << b) : $urandom;
      e = word & SOFT_RESET_MASK;
      wr((b == 46) ? 8'h10 : SOFT_RESET_OFS, word);
      if (b == 46) e = 32'h0;
      #1 ck("pulse", e, hit);
      @(posedge i_core_clk);
      #1 ck("clear", 32'h0, hit);
      @(posedge i_core_clk);
    end
    rd(SOFT_RESET_OFS, 32'h0);
    rd(8'h10, 32'h0);
    $display("Test soft resets done");
    results();
  end
endmodule
